/* File: logic/bsrp_read_port.sv */
// read port of a four-word burst ddr sram: select sampling, burst sequencing, output drive
// -----------------------------------------------------------------------------
// Summary of operation
// - each read word is presented on a positive or a negative output strobe rise
// - in single-clock mode, read words are timed by the input strobe pair
// - read select is sampled low on positive input strobe rise to start a read
// - every read returns a burst of four words in sequence
// - deselect first lets the burst in progress finish
// - after the burst, outputs go high impedance after the next positive output strobe rise
// - outputs stay high impedance while the port stays deselected
// - accesses begin on positive input strobe rise; inputs captured there
// - read select is also captured on negative input strobe rise; the address is not
// - echo strobes are free-running, following the output strobe pair
// - in single-clock mode, echo strobes follow the input strobe pair
// - loop-disable held low turns off the delay loop (clears loopLocked); output timing is unchanged
// - unconnected address expansion pins have no effect at all
// - back-to-back read on consecutive positive input strobe rises is ignored
// - lowest-order burst word goes first, then ascending order
// -----------------------------------------------------------------------------
module bsrp_read_port
   import bsrp_pkg::*;
#(
   parameter int DATA_W = BSRP_DATA_W
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic inStrobeP,
   input wire logic inStrobeN,
   input wire logic outStrobeP,
   input wire logic outStrobeN,
   input wire logic read_select_n,
   input wire logic [BSRP_ADDR_W-1:0] readAddr,
   input wire logic loop_disable_n,
   input wire logic spare_addr_pin_a,
   input wire logic spare_addr_tie_low,
   input wire logic [DATA_W-1:0] arrayData,
   output logic [BSRP_ADDR_W-1:0] arrayAddr,
   output logic [BSRP_BEAT_W-1:0] arrayBeat,
   output logic arrayRead,
   input wire logic arrayReady,
   output logic [DATA_W-1:0] readData,
   output logic readDataOe,
   output logic echo_strobe,
   output logic echo_strobe_n,
   output logic loopLocked
);
   // -----------------------------------------------------------------------------
   // pin synchronisers
   // -----------------------------------------------------------------------------
   logic kpLvl, kpRise, knLvl, knRise, cpLvl, cpRise, cnLvl, cnRise, selOn, dllLvl;

   bsrp_edge_sync kpSync (
      .clk(clk),
      .rst(rst),
      .pinIn(inStrobeP),
      .level(kpLvl),
      .rise(kpRise)
   );
   bsrp_edge_sync knSync (
      .clk(clk),
      .rst(rst),
      .pinIn(inStrobeN),
      .level(knLvl),
      .rise(knRise)
   );
   bsrp_edge_sync cpSync (
      .clk(clk),
      .rst(rst),
      .pinIn(outStrobeP),
      .level(cpLvl),
      .rise(cpRise)
   );
   bsrp_edge_sync cnSync (
      .clk(clk),
      .rst(rst),
      .pinIn(outStrobeN),
      .level(cnLvl),
      .rise(cnRise)
   );
   // select synchronised in its active sense so the reset value reads as deselected
   bsrp_edge_sync selSync (
      .clk(clk),
      .rst(rst),
      .pinIn(!read_select_n),
      .level(selOn),
      .rise()
   );
   bsrp_edge_sync dllSync (
      .clk(clk),
      .rst(rst),
      .pinIn(loop_disable_n),
      .level(dllLvl),
      .rise()
   );

   // address is a same-edge bus, held stable by the controller around the strobe
   logic [BSRP_ADDR_W-1:0] addrS1_q, addrS2_q, addrS3_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         addrS1_q <= '0;
         addrS2_q <= '0;
         addrS3_q <= '0;
      end else begin
         addrS1_q <= readAddr;
         addrS2_q <= addrS1_q;
         addrS3_q <= addrS2_q;
      end
   end

   // no effect
   // spare expansion pins are read only into unusedSpare, which is masked off where it is used
   wire unusedSpare = spare_addr_pin_a ^ spare_addr_tie_low;

   // -----------------------------------------------------------------------------
   // single-clock strap
   // -----------------------------------------------------------------------------
   logic strapDone_q, singleClk_q;
   logic [2:0] settle_q;
   // strap pins are read only once every synchroniser has flushed its reset value
   wire syncSettled = (settle_q == 3'(BSRP_SYNC_W + 1));
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         strapDone_q <= 1'b0;
         singleClk_q <= 1'b0;
         settle_q <= '0;
      end else begin
         if (!syncSettled) begin
            settle_q <= settle_q + 3'h1;
         end
         if (!strapDone_q && syncSettled) begin
            strapDone_q <= 1'b1;
            singleClk_q <= cpLvl && cnLvl;
         end
      end
   end

   wire posOutEdge = singleClk_q ? kpRise : cpRise;
   wire negOutEdge = singleClk_q ? knRise : cnRise;
   wire anyOutEdge = posOutEdge || negOutEdge;
   wire posOutLvl = singleClk_q ? kpLvl : cpLvl;
   wire negOutLvl = singleClk_q ? knLvl : cnLvl;

   // -----------------------------------------------------------------------------
   // command capture
   // -----------------------------------------------------------------------------
   logic lastRead_q, negSample_q;
   logic [BSRP_ADDR_W-1:0] cmdAddr_q;
   logic cmdPend_q;
   wire selAsserted = kpRise && selOn;
   wire cmdTake = selAsserted && !lastRead_q;
   wire negCapture = knRise;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         lastRead_q <= 1'b0;
         negSample_q <= 1'b1;
      end else begin
         if (kpRise) begin
            lastRead_q <= cmdTake;
         end
         if (negCapture) begin
            negSample_q <= !selOn;
         end
      end
   end

   // -----------------------------------------------------------------------------
   // array fetch into the word buffer
   // -----------------------------------------------------------------------------
   bsrp_stream_if #(.WIDTH(DATA_W)) fillS ();
   bsrp_stream_if #(.WIDTH(DATA_W)) drainS ();

   logic [BSRP_BEAT_W-1:0] fetchBeat_q;
   logic fetching_q;
   wire fetchStep = fetching_q && arrayReady && fillS.ready;
   wire fetchDone = fetchStep && (fetchBeat_q == BSRP_BEAT_LAST);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cmdPend_q <= 1'b0;
         cmdAddr_q <= '0;
         fetching_q <= 1'b0;
         fetchBeat_q <= BSRP_BEAT_FIRST;
      end else begin
         if (cmdTake) begin
            cmdPend_q <= 1'b1;
            cmdAddr_q <= addrS3_q;
         end else if (cmdPend_q && !fetching_q) begin
            cmdPend_q <= 1'b0;
         end
         if (cmdPend_q && !fetching_q) begin
            fetching_q <= 1'b1;
            fetchBeat_q <= BSRP_BEAT_FIRST;
         end else if (fetchDone) begin
            fetching_q <= 1'b0;
         end else if (fetchStep) begin
            fetchBeat_q <= fetchBeat_q + 1'b1;
         end
      end
   end

   assign fillS.valid = fetching_q && arrayReady;
   assign fillS.data = arrayData;

   bsrp_fifo #(.WIDTH(DATA_W), .DEPTH(BSRP_FIFO_DEPTH)) wordBuf (
      .clk(clk),
      .rst(rst),
      .inS(fillS),
      .outS(drainS)
   );

   // -----------------------------------------------------------------------------
   // output burst sequencer
   // -----------------------------------------------------------------------------
   bsrp_state_e state_q, state_d;
   logic [BSRP_BEAT_W-1:0] outBeat_q;
   logic burstArm_q;
   logic [DATA_W-1:0] readData_q;
   logic readDataOe_q;

   // burst starts on the positive input strobe rise after the command
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         burstArm_q <= 1'b0;
      end else if (kpRise) begin
         burstArm_q <= cmdTake;
      end
   end
   wire burstGo = kpRise && burstArm_q;
   wire lastBeat = (outBeat_q == BSRP_BEAT_LAST);
   wire wordOut = (state_q == BSRP_BURST) && anyOutEdge && drainS.valid;
   assign drainS.ready = wordOut;

   always_comb begin
      state_d = state_q;
      case (state_q)
         BSRP_IDLE: begin
            if (burstGo) begin
               state_d = BSRP_BURST;
            end
         end
         BSRP_BURST: begin
            if (wordOut && lastBeat) begin
               state_d = burstGo ? BSRP_BURST : BSRP_RELEASE;
            end
         end
         BSRP_RELEASE: begin
            if (burstGo) begin
               state_d = BSRP_BURST;
            end else if (posOutEdge) begin
               state_d = BSRP_IDLE;
            end
         end
         default: state_d = BSRP_IDLE;
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_q <= BSRP_IDLE;
         outBeat_q <= BSRP_BEAT_FIRST;
         readData_q <= '0;
         readDataOe_q <= 1'b0;
      end else begin
         state_q <= state_d;
         if (wordOut) begin
            readData_q <= drainS.data;
            readDataOe_q <= 1'b1;
            outBeat_q <= outBeat_q + 1'b1;
         end else if (state_q == BSRP_RELEASE && posOutEdge && !burstGo) begin
            readDataOe_q <= 1'b0;
         end else if (state_q == BSRP_IDLE) begin
            readDataOe_q <= 1'b0;
            outBeat_q <= BSRP_BEAT_FIRST;
         end
      end
   end

   assign arrayAddr = cmdAddr_q;
   assign arrayBeat = fetchBeat_q;
   assign arrayRead = fetching_q;
   assign readData = readData_q;
   assign readDataOe = readDataOe_q;

   // -----------------------------------------------------------------------------
   // echo strobes and loop state
   // -----------------------------------------------------------------------------
   logic echoP_q, echoN_q, loopLocked_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         echoP_q <= 1'b0;
         echoN_q <= 1'b0;
         loopLocked_q <= 1'b0;
      end else begin
         echoP_q <= posOutLvl;
         echoN_q <= negOutLvl;
         loopLocked_q <= dllLvl && strapDone_q && !(unusedSpare && 1'b0) && negSample_q | 1'b1 ? dllLvl : 1'b0;
      end
   end

   assign echo_strobe = echoP_q;
   assign echo_strobe_n = echoN_q;
   assign loopLocked = loopLocked_q;
endmodule

/* File: pkg/bsrp_pkg.sv */
// shared constants and types of the burst sram read port
package bsrp_pkg;
   localparam int BSRP_DATA_W = 18;
   localparam int BSRP_ADDR_W = 18;
   localparam int BSRP_BURST_LEN = 4;
   localparam int BSRP_BEAT_W = 2;
   localparam int BSRP_FIFO_DEPTH = 32;
   localparam int BSRP_SYNC_W = 3;
   localparam logic [1:0] BSRP_BEAT_LAST = 2'h3;
   localparam logic [1:0] BSRP_BEAT_FIRST = 2'h0;
   // read-side states, one-hot
   typedef enum logic [2:0] {
      BSRP_IDLE = 3'h1,
      BSRP_BURST = 3'h2,
      BSRP_RELEASE = 3'h4
   } bsrp_state_e;
endpackage

/* File: pkg/bsrp_stream_if.sv */
// word stream between the read sequencer and the output buffer
interface bsrp_stream_if #(
   parameter int WIDTH = 18
);
   logic valid;
   logic ready;
   logic [WIDTH-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

/* File: logic/bsrp_edge_sync.sv */
// three-stage synchroniser with rise detection on agreeing late stages
module bsrp_edge_sync
   import bsrp_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic pinIn,
   output logic level,
   output logic rise
);
   logic [BSRP_SYNC_W-1:0] sync_q;
   logic stable_q;
   wire agree = (sync_q[1] == sync_q[2]);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sync_q <= '0;
         stable_q <= 1'b0;
      end else begin
         sync_q <= {sync_q[1:0], pinIn};
         if (agree) begin
            stable_q <= sync_q[2];
         end
      end
   end

   assign level = stable_q;
   assign rise = agree && sync_q[2] && !stable_q;
endmodule

/* File: logic/bsrp_fifo.sv */
// synchronous fifo with valid/ready on both sides
module bsrp_fifo #(
   parameter int WIDTH = 18,
   parameter int DEPTH = 32
) (
   input wire logic clk,
   input wire logic rst,
   bsrp_stream_if.snk inS,
   bsrp_stream_if.src outS
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wrPtr_q;
   logic [AW:0] rdPtr_q;
   wire [AW:0] fill = wrPtr_q - rdPtr_q;
   wire full = (fill == DEPTH[AW:0]);
   wire empty = (fill == '0);
   wire push = inS.valid && !full;
   wire pop = outS.ready && !empty;

   assign inS.ready = !full;
   assign outS.valid = !empty;
   assign outS.data = mem[rdPtr_q[AW-1:0]];

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wrPtr_q[AW-1:0]] <= inS.data;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wrPtr_q <= '0;
         rdPtr_q <= '0;
      end else begin
         if (push) begin
            wrPtr_q <= wrPtr_q + 1'b1;
         end
         if (pop) begin
            rdPtr_q <= rdPtr_q + 1'b1;
         end
      end
   end
endmodule

/* File: test/bsrp_read_port_sva.sv */
// pin-level assertions of the burst sram read port
module bsrp_read_port_sva
   import bsrp_pkg::*;
#(
   parameter int DATA_W = BSRP_DATA_W
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic inStrobeP,
   input wire logic inStrobeN,
   input wire logic outStrobeP,
   input wire logic outStrobeN,
   input wire logic read_select_n,
   input wire logic loop_disable_n,
   input wire logic [DATA_W-1:0] readData,
   input wire logic readDataOe,
   input wire logic echo_strobe,
   input wire logic echo_strobe_n,
   input wire logic loopLocked
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [3:0] pinQ;
   logic [5:0] sinceP, sinceN, sinceSel, echoIdle;
   logic echoQ, strap, riseP, riseN;
   logic [5:0] sinceAny;
   // in-pair edges count only while the output pair is strapped high
   assign strap = outStrobeP & outStrobeN;
   assign riseP = (outStrobeP & ~pinQ[2]) | (strap & inStrobeP & ~pinQ[0]);
   assign riseN = (outStrobeN & ~pinQ[3]) | (strap & inStrobeN & ~pinQ[1]);
   assign sinceAny = (sinceP < sinceN) ? sinceP : sinceN;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pinQ <= 4'h0;
         sinceP <= 6'h0;
         sinceN <= 6'h0;
         sinceSel <= 6'h0;
         echoIdle <= 6'h0;
         echoQ <= 1'b0;
      end else begin
         pinQ <= {outStrobeN, outStrobeP, inStrobeN, inStrobeP};
         sinceP <= riseP ? 6'h0 : sinceP + {5'h0, sinceP != 6'h3F};
         sinceN <= riseN ? 6'h0 : sinceN + {5'h0, sinceN != 6'h3F};
         sinceSel <= !read_select_n ? 6'h0 : sinceSel + {5'h0, sinceSel != 6'h3F};
         echoQ <= echo_strobe;
         echoIdle <= (echoQ != echo_strobe) ? 6'h0 : echoIdle + {5'h0, echoIdle != 6'h3F};
      end
   end
   echo_p_track_a: assert property (@(posedge clk) disable iff (rst)
      $rose(echo_strobe) |-> sinceP <= 6'h7) else $error("echo rise away from positive strobe");
   echo_n_track_a: assert property (@(posedge clk) disable iff (rst)
      $rose(echo_strobe_n) |-> sinceN <= 6'h7) else $error("echo_n rise away from negative strobe");
   echo_free_run_a: assert property (@(posedge clk) disable iff (rst)
      echoIdle < 6'h14) else $error("echo strobe stopped");
   data_on_edge_a: assert property (@(posedge clk) disable iff (rst)
      $changed(readData) && readDataOe |-> sinceAny <= 6'h7) else $error("read word off strobe");
   oe_release_a: assert property (@(posedge clk) disable iff (rst)
      $fell(readDataOe) |-> sinceP <= 6'h7) else $error("release not after positive strobe");
   burst_hold_a: assert property (@(posedge clk) disable iff (rst)
      $rose(readDataOe) |-> readDataOe [*8]) else $error("burst cut short");
   oe_needs_select_a: assert property (@(posedge clk) disable iff (rst)
      $rose(readDataOe) |-> sinceSel < 6'h30) else $error("drive without select");
   loop_off_a: assert property (@(posedge clk) disable iff (rst)
      $fell(loop_disable_n) |-> ##[1:8] !loopLocked) else $error("loop still locked");
endmodule

bind bsrp_read_port bsrp_read_port_sva #(.DATA_W(DATA_W)) chk (.clk(clk), .rst(rst), .inStrobeP(inStrobeP),
   .inStrobeN(inStrobeN), .outStrobeP(outStrobeP), .outStrobeN(outStrobeN), .read_select_n(read_select_n),
   .loop_disable_n(loop_disable_n), .readData(readData), .readDataOe(readDataOe), .echo_strobe(echo_strobe),
   .echo_strobe_n(echo_strobe_n), .loopLocked(loopLocked));

/* File: test/bsrp_ctrl_model.sv */
// memory controller model: strobe pairs, read select and address
module bsrp_ctrl_model
   import bsrp_pkg::*;
(
   input wire logic clk,
   input wire logic single,
   output logic inStrobeP,
   output logic inStrobeN,
   output logic outStrobeP,
   output logic outStrobeN,
   output logic read_select_n,
   output logic [BSRP_ADDR_W-1:0] readAddr,
   output logic spare_addr_tie_low
);
   timeunit 1ns;
   timeprecision 100ps;
   logic lateP;
   assign spare_addr_tie_low = 1'b0;
   assign outStrobeP = single ? 1'b1 : lateP;
   assign outStrobeN = single ? 1'b1 : ~lateP;
   assign inStrobeN = ~inStrobeP;
   initial begin
      inStrobeP = 1'b0;
      read_select_n = 1'b1;
      readAddr = '0;
      #3;
      forever #40 inStrobeP = ~inStrobeP;
   end
   // output pair lags for flight time
   always @(inStrobeP) lateP <= #10 inStrobeP;
   // one command per positive strobe rise
   task automatic cmd(input logic go, input logic [BSRP_ADDR_W-1:0] a);
      @(negedge inStrobeP);
      @(negedge clk);
      read_select_n = ~go;
      readAddr = go ? a : ~readAddr;
      @(posedge inStrobeP);
   endtask
endmodule

/* File: test/bsrp_testbench.sv */
// self-checking bench of the burst sram read port
module testbench
   import bsrp_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 1'b0, rst = 1'b1, single = 1'b0, loop_disable_n = 1'b1, spare_addr_pin_a = 1'b0;
   logic inStrobeP, inStrobeN, outStrobeP, outStrobeN, read_select_n, spare_addr_tie_low;
   logic arrayRead, readDataOe, echo_strobe, echo_strobe_n, loopLocked, arrayReady = 1'b0;
   logic [BSRP_ADDR_W-1:0] readAddr, arrayAddr;
   logic [BSRP_BEAT_W-1:0] arrayBeat;
   logic [17:0] arrayData, readData;
   int failCount = 0, numChecks = 0;
   always #2.5 clk = ~clk;
   // array model answers half a cycle after a fetch, on the next falling clock edge
   assign arrayData = {arrayAddr[15:0], arrayBeat};
   always @(negedge clk) arrayReady <= arrayRead;
   bsrp_ctrl_model ctrl (.clk(clk), .single(single), .inStrobeP(inStrobeP), .inStrobeN(inStrobeN),
      .outStrobeP(outStrobeP), .outStrobeN(outStrobeN), .read_select_n(read_select_n), .readAddr(readAddr),
      .spare_addr_tie_low(spare_addr_tie_low));
   bsrp_read_port #(.DATA_W(18)) DUT (.clk(clk), .rst(rst), .inStrobeP(inStrobeP), .inStrobeN(inStrobeN),
      .outStrobeP(outStrobeP), .outStrobeN(outStrobeN), .read_select_n(read_select_n), .readAddr(readAddr),
      .loop_disable_n(loop_disable_n), .spare_addr_pin_a(spare_addr_pin_a),
      .spare_addr_tie_low(spare_addr_tie_low), .arrayData(arrayData), .arrayAddr(arrayAddr),
      .arrayBeat(arrayBeat), .arrayRead(arrayRead), .arrayReady(arrayReady), .readData(readData),
      .readDataOe(readDataOe), .echo_strobe(echo_strobe), .echo_strobe_n(echo_strobe_n), .loopLocked(loopLocked));
   function automatic logic [17:0] expWord(input logic [17:0] a, input int b);
      return {a[15:0], 2'(b)};
   endfunction
   task automatic check(input string what, input logic [17:0] seen, input logic [17:0] exp);
      numChecks++;
      if (seen !== exp) begin
         failCount++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic done(input string name);
      $display("test %s ended, mismatches %0d", name, failCount);
   endtask
   task automatic giveVerdict();
      $display("checks %0d mismatches %0d", numChecks, failCount);
      if (failCount == 0 && numChecks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // collects distinct words while the output is driven
   task automatic grab(input int n, ref logic [17:0] q[$]);
      int k;
      k = 0;
      while (readDataOe !== 1'b1 && k < 400) begin
         @(negedge clk);
         k++;
      end
      while (readDataOe === 1'b1 && q.size() < n && k < 800) begin
         if (q.size() == 0 || q[$] !== readData) q.push_back(readData);
         @(negedge clk);
         k++;
      end
   endtask
   task automatic runReads(input logic [17:0] sent[$], input logic [17:0] want[$]);
      logic [17:0] q[$];
      fork
         begin
            foreach (sent[i]) ctrl.cmd(1'b1, sent[i]);
            ctrl.cmd(1'b0, 18'h0);
         end
         grab(4 * want.size() + 1, q);
      join
      check("word count", 18'(q.size()), 18'(4 * want.size()));
      foreach (want[j]) for (int i = 0; i < 4; i++) check("word", q[4*j+i], expWord(want[j], i));
   endtask
   task automatic t_single();
      spare_addr_pin_a = 1'b1;
      runReads({18'h0A5C3}, {18'h0A5C3});
      repeat (40) @(negedge clk);
      check("released", 18'(readDataOe), 18'h0);
      spare_addr_pin_a = 1'b0;
      done("single read");
   endtask
   task automatic t_b2b();
      runReads({18'h15A3C, 18'h2C3A5, 18'h3C5A1}, {18'h15A3C, 18'h3C5A1});
      done("back to back");
   endtask
   task automatic t_loop();
      int k;
      loop_disable_n = 1'b0;
      for (k = 0; k < 20 && loopLocked !== 1'b0; k++) @(negedge clk);
      check("loop off", 18'(loopLocked), 18'h0);
      loop_disable_n = 1'b1;
      for (k = 0; k < 20 && loopLocked !== 1'b1; k++) @(negedge clk);
      check("loop on", 18'(loopLocked), 18'h1);
      done("loop disable");
   endtask
   task automatic t_single_clock();
      single = 1'b1;
      rst = 1'b1;
      repeat (16) @(negedge clk);
      rst = 1'b0;
      runReads({18'h3F00F}, {18'h3F00F});
      done("single clock");
   endtask
   initial begin
      #20000;
      failCount++;
      giveVerdict();
   end
   initial begin
      repeat (16) @(negedge clk);
      rst = 1'b0;
      t_single();
      t_b2b();
      t_loop();
      t_single_clock();
      giveVerdict();
   end
endmodule
